// File: rpl_pkg.sv
package rpl_pkg;
    // address space and region granularity
    localparam int          ADDR_W      = 32;              // flat address width
    localparam int          GRAN_BITS   = 6;               // 64-byte blocks
    localparam logic [5:0]  GRAN_ZEROS  = 6'h00;           // padding below a base
    localparam logic [5:0]  GRAN_ONES   = 6'h3f;           // padding below a limit
    // base register field layout
    localparam int          BASE_XN_POS = 0;               // execute-never bit
    localparam int          BASE_AP_LO  = 1;               // access permission low bit
    localparam int          BASE_AP_HI  = 2;               // access permission high bit
    localparam int          BASE_SH_LO  = 3;               // shareability low bit
    localparam int          BASE_SH_HI  = 4;               // shareability high bit
    // limit register field layout
    localparam int          LIM_EN_POS  = 0;               // region enable bit
    localparam int          LIM_IDX_LO  = 1;               // attribute_index low bit
    localparam int          LIM_IDX_HI  = 3;               // attribute_index high bit
    // attribute indirection
    localparam int          ATTR_W      = 8;               // one attribute field
    localparam int          IND_REG_W   = 32;              // one indirection register
    localparam logic [7:0]  BG_ATTR     = 8'h00;           // attribute of the default map
    localparam logic [1:0]  BG_SHARE    = 2'h2;            // default map: outer shareable
    localparam logic [3:0]  ATTR_DEVICE = 4'h0;            // upper nibble zero means device
    // exception levels of a request
    localparam logic [1:0]  LVL_USER    = 2'h0;            // user_level
    localparam logic [1:0]  LVL_KERNEL  = 2'h1;            // kernel_level
    localparam logic [1:0]  LVL_HYP     = 2'h2;            // hypervisor_level
    // fault codes of a response
    localparam logic [1:0]  FLT_NONE    = 2'h0;            // access allowed
    localparam logic [1:0]  FLT_PERM_S1 = 2'h1;            // first-stage permission fault
    localparam logic [1:0]  FLT_PERM_S2 = 2'h2;            // second-stage permission fault
    localparam logic [1:0]  FLT_ROUTE   = 2'h3;            // kernel access while routed
endpackage : rpl_pkg

// File: rpl_lookup.sv
`timescale 1ns/1ps
module rpl_lookup #(
    parameter int N_REGIONS = 16,   // regions per unit
    parameter int GUEST_W   = 8     // guest_identifier width
) (
    input  wire logic                          i_mclk,
    input  wire logic                          i_arst_n,
    // access request from the pipeline
    input  wire logic                          i_req_valid,
    input  wire logic [31:0]                   i_req_addr,
    input  wire logic [1:0]                    i_req_level,
    input  wire logic                          i_req_fetch,
    input  wire logic                          i_req_write,
    // controls
    input  wire logic                          i_kernel_unit_en,
    input  wire logic                          i_hyp_unit_en,
    input  wire logic                          i_stage2_enable,
    input  wire logic                          i_general_exception_route,
    // region tables and indirection registers
    input  wire logic [N_REGIONS*32-1:0]       i_kernel_region_base_reg,
    input  wire logic [N_REGIONS*32-1:0]       i_kernel_region_limit_reg,
    input  wire logic [N_REGIONS*32-1:0]       i_hyp_region_base_reg,
    input  wire logic [N_REGIONS*32-1:0]       i_hyp_region_limit_reg,
    input  wire logic [63:0]                   i_attribute_indirection_reg,
    input  wire logic [63:0]                   i_hyp_attribute_indirection_reg,
    // barrier request
    input  wire logic                          i_bar_valid,
    input  wire logic                          i_bar_sync,
    input  wire logic [1:0]                    i_bar_level,
    input  wire logic [GUEST_W-1:0]            i_guest_identifier,
    // lookup response, one cycle after the request
    output logic                               o_rsp_valid,
    output logic [31:0]                        o_rsp_addr,
    output logic                               o_rsp_hit,
    output logic [$clog2(N_REGIONS)-1:0]       o_rsp_region,
    output logic [7:0]                         o_rsp_attr,
    output logic [1:0]                         o_rsp_share,
    output logic [1:0]                         o_rsp_fault,
    output logic                               o_rsp_background,
    // barrier ordering scope, one cycle after the barrier
    output logic                               o_bar_valid,
    output logic                               o_bar_sync,
    output logic                               o_bar_hyp_only,
    output logic [GUEST_W-1:0]                 o_bar_guest_identifier
);

    localparam int RW = $clog2(N_REGIONS);     // region index width

    // one matched region from either unit
    logic          k_hit;                      // kernel unit hit
    logic [RW-1:0] k_idx;                      // kernel region number
    logic [31:0]   k_base;                     // kernel hit base register
    logic [31:0]   k_lim;                      // kernel hit limit register
    logic          h_hit;                      // hypervisor unit hit
    logic [RW-1:0] h_idx;                      // hypervisor region number
    logic [31:0]   h_base;                     // hypervisor hit base register
    logic [31:0]   h_lim;                      // hypervisor hit limit register

    // padded range compare of one region
    function automatic logic in_region(input logic [31:0] base, input logic [31:0] lim,
                                       input logic [31:0] addr);
        logic [31:0] lo;
        logic [31:0] hi;
        lo = {base[31:rpl_pkg::GRAN_BITS], rpl_pkg::GRAN_ZEROS};
        hi = {lim[31:rpl_pkg::GRAN_BITS], rpl_pkg::GRAN_ONES};
        // limit below base leaves lo > hi, so nothing matches
        return lim[rpl_pkg::LIM_EN_POS] && (addr >= lo) && (addr <= hi);
    endfunction : in_region

    // access permission check of one region
    function automatic logic perm_ok(input logic [31:0] base, input logic user,
                                     input logic write, input logic fetch);
        logic ro;
        logic unpriv;
        ro     = base[rpl_pkg::BASE_AP_HI];   // read-only
        unpriv = base[rpl_pkg::BASE_AP_LO];   // user access allowed
        return !(write && ro) && !(user && !unpriv) && !(fetch && base[rpl_pkg::BASE_XN_POS]);
    endfunction : perm_ok

    // attribute_index: top bit picks register, low two bits pick field
    function automatic logic [7:0] attr_sel(input logic [63:0] ind, input logic [31:0] lim);
        logic [2:0]  idx;
        logic [31:0] reg_w;
        idx   = lim[rpl_pkg::LIM_IDX_HI:rpl_pkg::LIM_IDX_LO];
        reg_w = idx[2] ? ind[63:32] : ind[31:0];
        return reg_w[idx[1:0]*rpl_pkg::ATTR_W +: rpl_pkg::ATTR_W];
    endfunction : attr_sel

    // kernel unit search, lowest numbered hit wins
    always_comb begin
        k_hit  = 1'b0;
        k_idx  = '0;
        k_base = '0;
        k_lim  = '0;
        for (int i = N_REGIONS - 1; i >= 0; i--) begin
            if (in_region(i_kernel_region_base_reg[i*32 +: 32],
                          i_kernel_region_limit_reg[i*32 +: 32], i_req_addr)) begin
                k_hit  = 1'b1;
                k_idx  = RW'(i);
                k_base = i_kernel_region_base_reg[i*32 +: 32];
                k_lim  = i_kernel_region_limit_reg[i*32 +: 32];
            end
        end
    end

    // hypervisor unit search, lowest numbered hit wins
    always_comb begin
        h_hit  = 1'b0;
        h_idx  = '0;
        h_base = '0;
        h_lim  = '0;
        for (int i = N_REGIONS - 1; i >= 0; i--) begin
            if (in_region(i_hyp_region_base_reg[i*32 +: 32],
                          i_hyp_region_limit_reg[i*32 +: 32], i_req_addr)) begin
                h_hit  = 1'b1;
                h_idx  = RW'(i);
                h_base = i_hyp_region_base_reg[i*32 +: 32];
                h_lim  = i_hyp_region_limit_reg[i*32 +: 32];
            end
        end
    end

    // per-access decision
    logic          is_hyp;        // hypervisor_level request
    logic          is_user;       // user_level request
    logic          routed;        // kernel access blocked by routing
    logic          s1_bg;         // first stage falls to background
    logic          s1_ok;         // first stage permits
    logic          s2_on;         // second stage applies
    logic          s2_ok;         // second stage permits
    logic [7:0]    s1_attr;       // first stage attribute
    logic [7:0]    s2_attr;       // second stage attribute
    logic [7:0]    attr_d;        // resulting attribute
    logic [1:0]    share_d;       // resulting shareability
    logic [1:0]    fault_d;       // resulting fault code
    logic          hit_d;         // a region matched
    logic [RW-1:0] region_d;      // matched region number

    // stage results; one region set serves fetch and data alike
    always_comb begin
        is_hyp  = (i_req_level == rpl_pkg::LVL_HYP);
        is_user = (i_req_level == rpl_pkg::LVL_USER);
        routed  = i_general_exception_route && (i_req_level == rpl_pkg::LVL_KERNEL);
        s2_on   = !is_hyp && i_stage2_enable;
        if (is_hyp) begin
            // single stage in the hypervisor unit
            s1_bg   = !(i_hyp_unit_en && h_hit);
            s1_ok   = s1_bg || perm_ok(h_base, 1'b0, i_req_write, i_req_fetch);
            s1_attr = s1_bg ? rpl_pkg::BG_ATTR
                            : attr_sel(i_hyp_attribute_indirection_reg, h_lim);
        end else begin
            // first stage in the kernel unit when enabled
            s1_bg   = !(i_kernel_unit_en && k_hit);
            // background map denies user access while the unit is on
            s1_ok   = s1_bg ? !(i_kernel_unit_en && is_user)
                            : perm_ok(k_base, is_user, i_req_write, i_req_fetch);
            s1_attr = s1_bg ? rpl_pkg::BG_ATTR
                            : attr_sel(i_attribute_indirection_reg, k_lim);
        end
        // second stage miss keeps the first stage result
        s2_ok   = !(s2_on && h_hit) || perm_ok(h_base, is_user, i_req_write, i_req_fetch);
        s2_attr = attr_sel(i_hyp_attribute_indirection_reg, h_lim);
        attr_d  = s1_attr;
        share_d = s1_bg ? rpl_pkg::BG_SHARE
                        : (is_hyp ? h_base[rpl_pkg::BASE_SH_HI:rpl_pkg::BASE_SH_LO]
                                  : k_base[rpl_pkg::BASE_SH_HI:rpl_pkg::BASE_SH_LO]);
        if (s2_on && h_hit) begin
            // device wins, otherwise the weaker nibble of each half
            if (s1_attr[7:4] == rpl_pkg::ATTR_DEVICE) begin
                attr_d = s1_attr;
            end else if (s2_attr[7:4] == rpl_pkg::ATTR_DEVICE) begin
                attr_d = s2_attr;
            end else begin
                attr_d[7:4] = (s1_attr[7:4] < s2_attr[7:4]) ? s1_attr[7:4] : s2_attr[7:4];
                attr_d[3:0] = (s1_attr[3:0] < s2_attr[3:0]) ? s1_attr[3:0] : s2_attr[3:0];
            end
            // wider shareability of the two stages
            if (h_base[rpl_pkg::BASE_SH_HI:rpl_pkg::BASE_SH_LO] > share_d) begin
                share_d = h_base[rpl_pkg::BASE_SH_HI:rpl_pkg::BASE_SH_LO];
            end
        end
        // fault priority: routing, then stage one, then stage two
        if (routed) begin
            fault_d = rpl_pkg::FLT_ROUTE;
        end else if (!s1_ok) begin
            fault_d = rpl_pkg::FLT_PERM_S1;
        end else if (!s2_ok) begin
            fault_d = rpl_pkg::FLT_PERM_S2;
        end else begin
            fault_d = rpl_pkg::FLT_NONE;
        end
        hit_d    = !s1_bg;
        region_d = is_hyp ? h_idx : k_idx;
    end

    // response register; address goes back untouched
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rsp_valid      <= 1'b0;
            o_rsp_addr       <= '0;
            o_rsp_hit        <= 1'b0;
            o_rsp_region     <= '0;
            o_rsp_attr       <= '0;
            o_rsp_share      <= '0;
            o_rsp_fault      <= rpl_pkg::FLT_NONE;
            o_rsp_background <= 1'b0;
        end else begin
            o_rsp_valid <= i_req_valid;
            if (i_req_valid) begin
                o_rsp_addr       <= i_req_addr;
                o_rsp_hit        <= hit_d;
                o_rsp_region     <= region_d;
                o_rsp_attr       <= attr_d;
                o_rsp_share      <= share_d;
                o_rsp_fault      <= fault_d;
                o_rsp_background <= !hit_d;
            end
        end
    end

    // barrier scope register
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_bar_valid            <= 1'b0;
            o_bar_sync             <= 1'b0;
            o_bar_hyp_only         <= 1'b0;
            o_bar_guest_identifier <= '0;
        end else begin
            o_bar_valid <= i_bar_valid;
            if (i_bar_valid) begin
                o_bar_sync             <= i_bar_sync;
                o_bar_hyp_only         <= (i_bar_level == rpl_pkg::LVL_HYP);
                o_bar_guest_identifier <= i_guest_identifier;
            end
        end
    end

    // checks on the response and the barrier scope
    AST_FLAT_ADDR: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_req_valid |=> o_rsp_valid && (o_rsp_addr == $past(i_req_addr)))
        else $error("response address differs from request address");

    AST_ROUTE_BLOCK: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_req_valid && i_general_exception_route && (i_req_level == rpl_pkg::LVL_KERNEL)
        |=> o_rsp_fault == rpl_pkg::FLT_ROUTE)
        else $error("kernel access allowed while routed");

    AST_HYP_ONE_STAGE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_req_valid && (i_req_level == rpl_pkg::LVL_HYP)
        |=> o_rsp_fault != rpl_pkg::FLT_PERM_S2)
        else $error("second stage applied to hypervisor access");

    AST_S1_WINS: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_req_valid && !routed && !s1_ok |=> o_rsp_fault == rpl_pkg::FLT_PERM_S1)
        else $error("first stage denial not reported");

    AST_S2_ONLY_AFTER_S1: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_req_valid && !routed && s1_ok && !i_stage2_enable
        |=> o_rsp_fault == rpl_pkg::FLT_NONE)
        else $error("fault raised with stage 2 off and stage 1 allowing");

    AST_MISS_BACKGROUND: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_req_valid && (i_req_level != rpl_pkg::LVL_HYP) && !k_hit
        |=> o_rsp_background && !o_rsp_hit && (o_rsp_attr == rpl_pkg::BG_ATTR || $past(s2_on)))
        else $error("miss not sent to background map");

    AST_KERNEL_EN_GATE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_req_valid && (i_req_level != rpl_pkg::LVL_HYP) && !i_kernel_unit_en
        |=> !o_rsp_hit)
        else $error("disabled kernel unit reported a hit");

    AST_HIT_REGION: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_req_valid && (i_req_level != rpl_pkg::LVL_HYP) && i_kernel_unit_en && k_hit
        |=> o_rsp_hit && (o_rsp_region == $past(k_idx)))
        else $error("kernel hit not reported with its region");

    AST_BAR_GUEST: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_bar_valid && (i_bar_level != rpl_pkg::LVL_HYP)
        |=> o_bar_valid && !o_bar_hyp_only && o_bar_guest_identifier == $past(i_guest_identifier))
        else $error("lower-level barrier scope wrong");

    AST_BAR_HYP: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_bar_valid && (i_bar_level == rpl_pkg::LVL_HYP) |=> o_bar_valid && o_bar_hyp_only)
        else $error("hypervisor barrier scope wrong");

endmodule : rpl_lookup

// File: rpl_core_model.sv
`timescale 1ns/1ps
// pipeline side: turns one bench request into one single-cycle lookup strobe
module rpl_core_model (
    input  wire logic        i_mclk,       // core clock
    input  wire logic        i_arst_n,     // async reset, active low
    input  wire logic        i_issue,      // bench asks for one access
    input  wire logic [31:0] i_addr,       // access address
    input  wire logic [1:0]  i_level,      // issuing level
    input  wire logic        i_fetch,      // instruction fetch
    input  wire logic        i_write,      // data write
    output logic             o_req_valid,  // one-cycle request strobe
    output logic [31:0]      o_req_addr,   // address to the unit
    output logic [1:0]       o_req_level,  // level to the unit
    output logic             o_req_fetch,  // fetch flag to the unit
    output logic             o_req_write   // write flag to the unit
);
    // fetches and data share one port and one region set
    // idle cycles flip every qualifier so a stale value never looks valid
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_req_valid <= 1'b0;
            o_req_addr  <= 32'h0;
            o_req_level <= 2'h0;
            o_req_fetch <= 1'b0;
            o_req_write <= 1'b0;
        end else begin
            o_req_valid <= i_issue;
            o_req_addr  <= i_issue ? i_addr : ~o_req_addr;
            o_req_level <= i_issue ? i_level : ~o_req_level;
            o_req_fetch <= i_issue ? i_fetch : ~o_req_fetch;
            o_req_write <= i_issue ? i_write : ~o_req_write;
        end
    end
endmodule : rpl_core_model

// File: rpl_lookup_bench.sv
`timescale 1ns/1ps
module rpl_lookup_bench;
    logic             mclk, arst_n, issue, ifetch, iwrite, qv, qf, qw;  // clock, reset, requests
    logic [31:0]      iaddr, qa;                                        // request address
    logic [1:0]       ilvl, ql, bar_lvl;                                // levels
    logic             ken, hen, s2, route, bar_v, bar_s;                // controls, barrier
    logic [7:0]       guest, ogid, at;                                  // guest ids, attribute
    logic [511:0]     kb, kl, hb, hl;                                   // region tables
    logic             rv, rh, rbg, bv, bs, bh;                          // response flags
    logic [3:0]       rr;                                               // hit region
    logic [1:0]       rs, rf;                                           // share, fault
    logic [31:0]      ra;                                               // response address
    int               mismatches = 0, n_checks = 0;                     // tallies
    rpl_core_model core (.i_mclk(mclk), .i_arst_n(arst_n), .i_issue(issue), .i_addr(iaddr),
        .i_level(ilvl), .i_fetch(ifetch), .i_write(iwrite), .o_req_valid(qv), .o_req_addr(qa),
        .o_req_level(ql), .o_req_fetch(qf), .o_req_write(qw));
    rpl_lookup uut (.i_mclk(mclk), .i_arst_n(arst_n), .i_req_valid(qv), .i_req_addr(qa),
        .i_req_level(ql), .i_req_fetch(qf), .i_req_write(qw), .i_kernel_unit_en(ken),
        .i_hyp_unit_en(hen), .i_stage2_enable(s2), .i_general_exception_route(route),
        .i_kernel_region_base_reg(kb), .i_kernel_region_limit_reg(kl),
        .i_hyp_region_base_reg(hb), .i_hyp_region_limit_reg(hl),
        .i_attribute_indirection_reg(64'h8877665544332211),
        .i_hyp_attribute_indirection_reg(64'hf0e0d0c0b0a09080), .i_bar_valid(bar_v),
        .i_bar_sync(bar_s), .i_bar_level(bar_lvl), .i_guest_identifier(guest),
        .o_rsp_valid(rv), .o_rsp_addr(ra), .o_rsp_hit(rh), .o_rsp_region(rr), .o_rsp_attr(at),
        .o_rsp_share(rs), .o_rsp_fault(rf), .o_rsp_background(rbg), .o_bar_valid(bv),
        .o_bar_sync(bs), .o_bar_hyp_only(bh), .o_bar_guest_identifier(ogid));
    // free-running core clock
    always #20 mclk = ~mclk;
    // base word: block address, shareability, read-only, user, execute-never
    function automatic logic [31:0] mk_b(input logic [31:0] a, input logic ro, input logic xn);
        mk_b = {a[31:6], 1'b0, 2'h1, ro, 1'b1, xn};
    endfunction : mk_b
    // limit word: block address, attribute index, enable
    function automatic logic [31:0] mk_l(input logic [31:0] a, input logic [2:0] ix);
        mk_l = {a[31:6], 2'h0, ix, 1'b1};
    endfunction : mk_l
    // compare one observed value against its expectation
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one lookup through the core model, answer one cycle after the taking edge
    task automatic look(input logic [31:0] a, input logic [1:0] lv, input logic f,
                        input logic w, input logic h, input logic [3:0] rg,
                        input logic [7:0] ea, input logic [1:0] ft);
        @(posedge mclk);
        issue  <= 1'b1;
        iaddr  <= a;
        ilvl   <= lv;
        ifetch <= f;
        iwrite <= w;
        @(posedge mclk);
        issue <= 1'b0;
        @(posedge mclk);
        #1;
        chk("rsp_valid", rv, 32'h1);
        chk("rsp_addr", ra, a);
        chk("rsp_fault", rf, ft);
        if (ft === rpl_pkg::FLT_NONE) begin
            chk("rsp_hit", rh, h);
            chk("rsp_background", rbg, !h);
            chk("rsp_attr", at, ea);
            if (h) chk("rsp_region", rr, rg);
            chk("rsp_share", rs, h ? 2'h1 : rpl_pkg::BG_SHARE);
        end
        @(posedge mclk);
        #1;
        chk("rsp_valid_drop", rv, 32'h0);
    endtask : look
    // one barrier, scope reported one cycle later
    task automatic bar(input logic [1:0] lv, input logic sy, input logic [7:0] g, input logic ho);
        @(posedge mclk);
        bar_v   <= 1'b1;
        bar_lvl <= lv;
        bar_s   <= sy;
        guest   <= g;
        @(posedge mclk);
        bar_v <= 1'b0;
        #1;
        chk("bar_valid", bv, 32'h1);
        chk("bar_sync", bs, sy);
        chk("bar_hyp_only", bh, ho);
        chk("bar_guest", ogid, g);
    endtask : bar
    // verdict and end of run
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    // cut a hang short well past the expected run length
    initial begin
        #(40 * 3000);
        mismatches++;
        complete_run;
    end
    // main sequence
    initial begin
        mclk    = 0;
        arst_n  = 0;
        issue   = 0;
        iaddr   = 0;
        ilvl    = 0;
        ifetch  = 0;
        iwrite  = 0;
        ken     = 1;
        hen     = 1;
        s2      = 0;
        route   = 0;
        bar_v   = 0;
        bar_s   = 0;
        bar_lvl = 0;
        guest   = 0;
        kb      = '0;
        kl      = '0;
        hb      = '0;
        hl      = '0;
        // disjoint regions only, one inverted
        kb[0 +: 32]  = mk_b(32'h1000, 0, 1);
        kl[0 +: 32]  = mk_l(32'h103f, 3'h5);
        kb[32 +: 32] = mk_b(32'h9000, 0, 0);
        kl[32 +: 32] = mk_l(32'h8000, 3'h1);
        kb[64 +: 32] = mk_b(32'h2000, 1, 0);
        kl[64 +: 32] = mk_l(32'h2fff, 3'h2);
        hb[0 +: 32]  = mk_b(32'h2000, 1, 0);
        hl[0 +: 32]  = mk_l(32'h2fff, 3'h3);
        hb[32 +: 32] = mk_b(32'h1000, 1, 0);
        hl[32 +: 32] = mk_l(32'h10ff, 3'h0);
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        look(32'h1000, rpl_pkg::LVL_KERNEL, 0, 0, 1, 4'h0, 8'h66, rpl_pkg::FLT_NONE);
        look(32'h103f, rpl_pkg::LVL_KERNEL, 0, 1, 1, 4'h0, 8'h66, rpl_pkg::FLT_NONE);
        look(32'h0fff, rpl_pkg::LVL_KERNEL, 0, 0, 0, 4'h0, 8'h00, rpl_pkg::FLT_NONE);
        look(32'h1040, rpl_pkg::LVL_KERNEL, 0, 0, 0, 4'h0, 8'h00, rpl_pkg::FLT_NONE);
        look(32'h8800, rpl_pkg::LVL_KERNEL, 0, 0, 0, 4'h0, 8'h00, rpl_pkg::FLT_NONE);
        look(32'h2abc, rpl_pkg::LVL_USER, 0, 0, 1, 4'h2, 8'h33, rpl_pkg::FLT_NONE);
        look(32'h1010, rpl_pkg::LVL_KERNEL, 1, 0, 1, 4'h0, 8'h66, rpl_pkg::FLT_PERM_S1);
        look(32'h2000, rpl_pkg::LVL_KERNEL, 1, 0, 1, 4'h2, 8'h33, rpl_pkg::FLT_NONE);
        $display("test kernel_unit done");
        look(32'h2010, rpl_pkg::LVL_HYP, 0, 0, 1, 4'h0, 8'hb0, rpl_pkg::FLT_NONE);
        look(32'h10ff, rpl_pkg::LVL_HYP, 0, 0, 1, 4'h1, 8'h80, rpl_pkg::FLT_NONE);
        look(32'h1100, rpl_pkg::LVL_HYP, 0, 0, 0, 4'h0, 8'h00, rpl_pkg::FLT_NONE);
        $display("test hyp_unit done");
        @(posedge mclk);
        s2 <= 1'b1;
        look(32'h1000, rpl_pkg::LVL_KERNEL, 0, 1, 1, 4'h0, 8'h66, rpl_pkg::FLT_PERM_S2);
        look(32'h2000, rpl_pkg::LVL_KERNEL, 0, 1, 1, 4'h2, 8'h33, rpl_pkg::FLT_PERM_S1);
        // both stages allow: per-nibble weaker of 8'h66 and 8'h80
        look(32'h1000, rpl_pkg::LVL_KERNEL, 0, 0, 1, 4'h0, 8'h60, rpl_pkg::FLT_NONE);
        look(32'h2010, rpl_pkg::LVL_HYP, 0, 0, 1, 4'h0, 8'hb0, rpl_pkg::FLT_NONE);
        @(posedge mclk);
        s2 <= 1'b0;
        look(32'h1000, rpl_pkg::LVL_KERNEL, 0, 1, 1, 4'h0, 8'h66, rpl_pkg::FLT_NONE);
        $display("test stage2 done");
        @(posedge mclk);
        route <= 1'b1;
        look(32'h1000, rpl_pkg::LVL_KERNEL, 0, 0, 1, 4'h0, 8'h66, rpl_pkg::FLT_ROUTE);
        look(32'h1000, rpl_pkg::LVL_USER, 0, 0, 1, 4'h0, 8'h66, rpl_pkg::FLT_NONE);
        @(posedge mclk);
        route <= 1'b0;
        ken <= 1'b0;
        look(32'h1000, rpl_pkg::LVL_KERNEL, 0, 0, 0, 4'h0, 8'h00, rpl_pkg::FLT_NONE);
        @(posedge mclk);
        ken <= 1'b1;
        kb <= '0;
        kl <= '0;
        @(posedge mclk);
        kb[0 +: 32] <= mk_b(32'h0, 0, 0);
        kl[0 +: 32] <= mk_l(32'hffffffc0, 3'h2);
        look(32'hffffffff, rpl_pkg::LVL_KERNEL, 0, 0, 1, 4'h0, 8'h33, rpl_pkg::FLT_NONE);
        look(32'h0, rpl_pkg::LVL_KERNEL, 0, 0, 1, 4'h0, 8'h33, rpl_pkg::FLT_NONE);
        $display("test controls done");
        bar(rpl_pkg::LVL_KERNEL, 1'b0, 8'h5a, 1'b0);
        bar(rpl_pkg::LVL_USER, 1'b1, 8'h3c, 1'b0);
        bar(rpl_pkg::LVL_HYP, 1'b1, 8'ha5, 1'b1);
        $display("test barrier done");
        complete_run;
    end
endmodule : rpl_lookup_bench
